// [hdl/ict_pkg.sv]
// Constants, types and register map of the isolated CAN transceiver control block.
// Assumes a 40 MHz clock and a 32-bit APB register bus with 12-bit byte addresses.
`default_nettype none

package ict_pkg;

    // =========================================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 25;
    // Plain default; the real figure is set per product
    localparam int unsigned DOM_TIMEOUT_NS   = 1000000;
    localparam int unsigned DOM_TIMEOUT_CYC  = (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_FILTER_NS   = 1000;
    localparam int unsigned WAKE_FILTER_CYC  = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES      = 2;

    // =========================================================================
    // Register map
    localparam logic [11:0] ADDR_CTRL        = 12'h000;
    localparam logic [11:0] ADDR_STATUS      = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h008;
    localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h010;

    localparam int unsigned CTRL_FORCE_STB   = 0;
    localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
    localparam logic [31:0] IRQ_ENABLE_RST   = 32'h0000_0000;

    // Status fields: mode one-hot in [2:0], then flags
    localparam int unsigned ST_MODE_LSB      = 0;
    localparam int unsigned ST_TIMEOUT       = 3;
    localparam int unsigned ST_OVERTEMP      = 4;
    localparam int unsigned ST_UV_STANDBY    = 5;
    localparam int unsigned ST_CTRL_UV       = 6;

    // Event bits, shared by irq status, clear and enable
    localparam int unsigned EV_TIMEOUT       = 0;
    localparam int unsigned EV_OVERTEMP      = 1;
    localparam int unsigned EV_UV_STANDBY    = 2;
    localparam int unsigned EV_SWITCHOFF     = 3;
    localparam int unsigned EV_CTRL_UV       = 4;
    localparam int unsigned NUM_EV           = 5;

    // =========================================================================
    // Types
    typedef enum logic [2:0] {
        ICT_OFF     = 3'b001,
        ICT_STANDBY = 3'b010,
        ICT_NORMAL  = 3'b100
    } ict_mode_e;

    typedef struct packed {
        logic txd;                  // Transmit data, low is dominant
        logic stb;                  // Standby control level
        logic stb_driven;           // Low while the standby pin floats
        logic ctrl_supply_low;      // controller_side_supply below ctrl_supply_low_threshold
        logic bus_supply_below_stb; // bus_side_supply below bus_supply_standby_threshold
        logic bus_supply_above_max; // bus_side_supply above that threshold's maximum
        logic bus_supply_below_off; // bus_side_supply below bus_supply_switchoff_threshold
        logic overtemp;             // Junction above shutdown_junction_temp
        logic rx_dominant;          // Normal receiver sees dominant
        logic lp_rx_dominant;       // Low-power receiver sees dominant
    } ict_pins_s;

    localparam ict_pins_s PINS_RST = '{txd: 1'b1, stb: 1'b1, default: 1'b0};

    typedef struct packed {
        logic drive_dominant;
        logic bias_mid;
        logic bias_gnd;
        logic connected;
        logic rx_normal_en;
        logic lp_rx_en;
    } ict_bus_s;

endpackage : ict_pkg

`default_nettype wire

// [hdl/ict_wake_filter.sv]
// Bus wake-up filter: output takes a new level only after it has been stable long enough.
// Assumes a synchronised input on the same clock.
`default_nettype none

module ict_wake_filter #(
    parameter int unsigned FILT_CYC = ict_pkg::WAKE_FILTER_CYC
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic din,
    output var  logic dout
);

    localparam int unsigned CW = $clog2(FILT_CYC + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(FILT_CYC);

    logic [CW-1:0] cnt_q;
    logic          dout_q;

    // =========================================================================
    // Stability counter
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q  <= '0;
            dout_q <= 1'b0;
        end else if (din == dout_q) begin
            cnt_q  <= '0;
        end else if (cnt_q == CNT_MAX) begin
            cnt_q  <= '0;
            dout_q <= din;
        end else begin
            cnt_q  <= cnt_q + CW'(1);
        end
    end

    assign dout = dout_q;

    // =========================================================================
    // Checks
    property p_filter_stable;
        @(posedge clock) disable iff (srst)
        $changed(dout_q) |-> $past(cnt_q) == CNT_MAX;
    endproperty
    a_filter_stable: assert property (p_filter_stable) else $error("filter passed short glitch");

endmodule : ict_wake_filter

`default_nettype wire

// [hdl/ict_ctrl.sv]
// Mode and fail-safe control of an isolated high-speed CAN transceiver, with APB registers.
// Assumes pin and supply flags arrive asynchronously and the bus analog front end is outside.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`default_nettype none

// Overview of operation
// - Normal mode drives bus from transmit data and returns bus state on receive data.
// - Good supplies: txd high gives recessive, rxd high; low gives dominant, rxd low.
// - Controller supply lost: dominant until time-out; recessive while bus supply ramps.
// - Bus supply unpowered: bus disconnected, rxd low, rxd rises when supply returns.
// - Standby input high selects Standby; low selects Normal.
// - Floating standby input defaults to Standby through a pull-up.
// - Standby: transmitter and normal receiver off, low-power receiver on, bus to ground.
// - Standby rxd follows low-power receiver through the wake filter.
// - Dominant timer starts on txd low; expiry disables transmitter, bus recessive.
// - A txd rising edge resets the timer and re-enables transmission.
// - Bus supply below standby threshold forces Standby until above its maximum.
// - Undervoltage standby still mirrors low-power receiver data onto rxd, slower.
// - Bus supply below switch-off: off, zero load; powers up again into Standby.
// - Controller supply undervoltage drives bus dominant and starts the timer.
// - After controller undervoltage rxd stays low until that supply is good.
// - Overtemperature disables the output drivers.
// - Drivers return only when temperature is low and txd is high.
module ict_ctrl #(
    parameter int unsigned DOM_TIMEOUT_CYC = ict_pkg::DOM_TIMEOUT_CYC,
    parameter int unsigned WAKE_FILTER_CYC = ict_pkg::WAKE_FILTER_CYC
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic             pready,
    output var  logic [31:0]      prdata,
    output var  logic             pslverr,
    input  wire ict_pkg::ict_pins_s pins,
    output var  logic             rxd,
    output var  ict_pkg::ict_bus_s  bus,
    output var  logic             irq
);

    localparam int unsigned PW = $bits(ict_pkg::ict_pins_s);
    localparam int unsigned TW = $clog2(DOM_TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] TO_LAST = TW'(DOM_TIMEOUT_CYC - 1);

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // =========================================================================
    // Input synchronisers
    logic [PW-1:0]      sync1_q;
    logic [PW-1:0]      sync2_q;
    ict_pkg::ict_pins_s pin_s;

    for (genvar i = 0; i < PW; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (srst) begin
                sync1_q[i] <= ict_pkg::PINS_RST[i];
                sync2_q[i] <= ict_pkg::PINS_RST[i];
            end else begin
                sync1_q[i] <= pins[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    assign pin_s = ict_pkg::ict_pins_s'(sync2_q);

    logic txd_prev_q;
    logic ctrl_uv_prev_q;
    logic txd_rise;
    logic ctrl_uv_end;

    always_ff @(posedge clock) begin
        if (srst) begin
            txd_prev_q     <= 1'b1;
            ctrl_uv_prev_q <= 1'b0;
        end else begin
            txd_prev_q     <= pin_s.txd;
            ctrl_uv_prev_q <= pin_s.ctrl_supply_low;
        end
    end

    assign txd_rise    = pin_s.txd && !txd_prev_q;
    assign ctrl_uv_end = ctrl_uv_prev_q && !pin_s.ctrl_supply_low;

    // =========================================================================
    // Registers
    localparam int unsigned NUM_EV = ict_pkg::NUM_EV;
    logic [31:0]       ctrl_q;
    logic [NUM_EV-1:0] irq_status_q;
    logic [NUM_EV-1:0] irq_enable_q;
    logic [NUM_EV-1:0] irq_events;
    logic [NUM_EV-1:0] irq_clear;
    logic [31:0]       status_word;
    logic [31:0]       rdata_d;
    logic              rd_err_d;
    logic [31:0]       prdata_q;
    logic              pslverr_q;
    logic              wr_acc;

    assign pready = psel && penable;
    assign wr_acc = psel && penable && pwrite;

    always_comb begin
        rdata_d  = 32'h0000_0000;
        rd_err_d = 1'b0;
        if (paddr == ict_pkg::ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end else if (paddr == ict_pkg::ADDR_STATUS) begin
            rdata_d = status_word;
        end else if (paddr == ict_pkg::ADDR_IRQ_STATUS) begin
            rdata_d = 32'(irq_status_q);
        end else if (paddr == ict_pkg::ADDR_IRQ_CLEAR) begin
            rdata_d = 32'h0000_0000;
        end else if (paddr == ict_pkg::ADDR_IRQ_ENABLE) begin
            rdata_d = 32'(irq_enable_q);
        end else begin
            rd_err_d = 1'b1;
        end
    end

    // Answer is prepared in the setup cycle and shown in the access cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= rd_err_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && pready;

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q       <= ict_pkg::CTRL_RST;
            irq_enable_q <= NUM_EV'(ict_pkg::IRQ_ENABLE_RST);
        end else if (wr_acc && paddr == ict_pkg::ADDR_CTRL) begin
            ctrl_q       <= {31'h0000_0000, pwdata[ict_pkg::CTRL_FORCE_STB]};
        end else if (wr_acc && paddr == ict_pkg::ADDR_IRQ_ENABLE) begin
            irq_enable_q <= pwdata[NUM_EV-1:0];
        end
    end

    assign irq_clear = (wr_acc && paddr == ict_pkg::ADDR_IRQ_CLEAR) ? pwdata[NUM_EV-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= irq_events | (irq_status_q & ~irq_clear);
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // =========================================================================
    // Supply undervoltage and overtemperature state
    logic uv_standby_q;
    logic ot_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            uv_standby_q <= 1'b1;
        end else if (pin_s.bus_supply_below_stb || pin_s.bus_supply_below_off) begin
            uv_standby_q <= 1'b1;
        end else if (pin_s.bus_supply_above_max) begin
            uv_standby_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ot_q <= 1'b0;
        end else if (pin_s.overtemp) begin
            ot_q <= 1'b1;
        end else if (pin_s.txd) begin
            ot_q <= 1'b0;
        end
    end

    // =========================================================================
    // Mode control
    ict_pkg::ict_mode_e mode_q;
    ict_pkg::ict_mode_e mode_d;
    logic               stb_sel;

    // Floating pin reads as standby; a lost controller supply cannot ask for it
    assign stb_sel = !pin_s.ctrl_supply_low && (pin_s.stb || !pin_s.stb_driven)
                     || ctrl_q[ict_pkg::CTRL_FORCE_STB];

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ict_pkg::ICT_OFF: begin
                if (!pin_s.bus_supply_below_off) begin
                    mode_d = ict_pkg::ICT_STANDBY;
                end
            end
            ict_pkg::ICT_STANDBY: begin
                if (pin_s.bus_supply_below_off) begin
                    mode_d = ict_pkg::ICT_OFF;
                end else if (!stb_sel && !uv_standby_q && !pin_s.bus_supply_below_stb) begin
                    mode_d = ict_pkg::ICT_NORMAL;
                end
            end
            ict_pkg::ICT_NORMAL: begin
                if (pin_s.bus_supply_below_off) begin
                    mode_d = ict_pkg::ICT_OFF;
                end else if (stb_sel || uv_standby_q || pin_s.bus_supply_below_stb) begin
                    mode_d = ict_pkg::ICT_STANDBY;
                end
            end
            default: begin
                mode_d = ict_pkg::ICT_OFF;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q <= ict_pkg::ICT_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    // =========================================================================
    // Dominant time-out
    logic          dom_req;
    logic [TW-1:0] dom_cnt_q;
    logic          timeout_q;

    assign dom_req = !pin_s.txd || pin_s.ctrl_supply_low;

    always_ff @(posedge clock) begin
        if (srst) begin
            dom_cnt_q <= '0;
        end else if (!dom_req || timeout_q || txd_rise) begin
            dom_cnt_q <= '0;
        end else begin
            dom_cnt_q <= dom_cnt_q + TW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            timeout_q <= 1'b0;
        end else if (txd_rise || (ctrl_uv_end && pin_s.txd)) begin
            timeout_q <= 1'b0;
        end else if (dom_req && dom_cnt_q == TO_LAST) begin
            timeout_q <= 1'b1;
        end
    end

    // =========================================================================
    // Bus and receive data outputs
    logic               tx_en;
    logic               lp_filt;
    logic               rxd_q;
    ict_pkg::ict_bus_s  bus_q;
    logic               is_normal;
    logic               is_standby;

    assign is_normal  = (mode_q == ict_pkg::ICT_NORMAL);
    assign is_standby = (mode_q == ict_pkg::ICT_STANDBY);
    assign tx_en      = is_normal && !timeout_q && !ot_q;

    ict_wake_filter #(
        .FILT_CYC (WAKE_FILTER_CYC)
    ) u_wake_filter (
        .clock (clock),
        .srst  (srst),
        .din   (pin_s.lp_rx_dominant),
        .dout  (lp_filt)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            bus_q <= '0;
            rxd_q <= 1'b0;
        end else begin
            bus_q.drive_dominant <= tx_en && dom_req;
            bus_q.bias_mid       <= is_normal;
            bus_q.bias_gnd       <= is_standby;
            bus_q.connected      <= (mode_q != ict_pkg::ICT_OFF);
            bus_q.rx_normal_en   <= is_normal;
            bus_q.lp_rx_en       <= is_standby;
            if (mode_q == ict_pkg::ICT_OFF || pin_s.ctrl_supply_low) begin
                rxd_q <= 1'b0;
            end else if (is_normal) begin
                rxd_q <= !pin_s.rx_dominant;
            end else begin
                rxd_q <= !lp_filt;
            end
        end
    end

    assign bus = bus_q;
    assign rxd = rxd_q;

    // =========================================================================
    // Status and events
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ict_pkg::ST_MODE_LSB +: 3] = mode_q;
        status_word[ict_pkg::ST_TIMEOUT]       = timeout_q;
        status_word[ict_pkg::ST_OVERTEMP]      = ot_q;
        status_word[ict_pkg::ST_UV_STANDBY]    = uv_standby_q;
        status_word[ict_pkg::ST_CTRL_UV]       = pin_s.ctrl_supply_low;
    end

    always_comb begin
        irq_events = '0;
        irq_events[ict_pkg::EV_TIMEOUT]    = dom_req && dom_cnt_q == TO_LAST && !timeout_q;
        irq_events[ict_pkg::EV_OVERTEMP]   = pin_s.overtemp && !ot_q;
        irq_events[ict_pkg::EV_UV_STANDBY] = pin_s.bus_supply_below_stb && !uv_standby_q;
        irq_events[ict_pkg::EV_SWITCHOFF]  = (mode_d == ict_pkg::ICT_OFF) && !(mode_q == ict_pkg::ICT_OFF);
        irq_events[ict_pkg::EV_CTRL_UV]    = pin_s.ctrl_supply_low && !ctrl_uv_prev_q;
    end

    // =========================================================================
    // Checks
    property p_off_quiet;
        mode_q == ict_pkg::ICT_OFF |=> !rxd_q && !bus_q.connected && !bus_q.drive_dominant;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off state not quiet");

    property p_normal_tx;
        is_normal && !timeout_q && !ot_q && !pin_s.txd |=> bus_q.drive_dominant;
    endproperty
    a_normal_tx: assert property (p_normal_tx) else $error("txd low not driven");

    property p_normal_rx;
        is_normal && !pin_s.ctrl_supply_low |=> rxd_q == !$past(pin_s.rx_dominant);
    endproperty
    a_normal_rx: assert property (p_normal_rx) else $error("rxd not following bus");

    property p_timeout_release;
        timeout_q && !txd_rise |=> !bus_q.drive_dominant ##1 !bus_q.drive_dominant;
    endproperty
    a_timeout_release: assert property (p_timeout_release) else $error("bus held after timeout");

    property p_txd_rise_clear;
        txd_rise |=> !timeout_q && dom_cnt_q == '0;
    endproperty
    a_txd_rise_clear: assert property (p_txd_rise_clear) else $error("timer not reset");

    property p_pullup;
        !pin_s.stb_driven && !pin_s.ctrl_supply_low && !pin_s.bus_supply_below_off
        |=> mode_q == ict_pkg::ICT_STANDBY;
    endproperty
    a_pullup: assert property (p_pullup) else $error("floating standby not standby");

    property p_standby_outputs;
        is_standby |=> bus_q.bias_gnd && bus_q.lp_rx_en && !bus_q.rx_normal_en
                       && !bus_q.drive_dominant;
    endproperty
    a_standby_outputs: assert property (p_standby_outputs) else $error("standby outputs");

    property p_uv_hold;
        uv_standby_q && !pin_s.bus_supply_above_max |=> !is_normal;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("left uv standby early");

    property p_ctrl_uv_rxd;
        pin_s.ctrl_supply_low |=> !rxd_q;
    endproperty
    a_ctrl_uv_rxd: assert property (p_ctrl_uv_rxd) else $error("rxd high in ctrl uv");

    property p_ot_hold;
        ot_q && !pin_s.txd |=> ot_q && !bus_q.drive_dominant;
    endproperty
    a_ot_hold: assert property (p_ot_hold) else $error("drivers back with txd low");

    property p_irq_sticky;
        irq_status_q[ict_pkg::EV_TIMEOUT] && !irq_clear[ict_pkg::EV_TIMEOUT]
        |=> irq_status_q[ict_pkg::EV_TIMEOUT];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("event bit lost");

    c_timeout: cover property (dom_req && dom_cnt_q == TO_LAST ##1 timeout_q);
    c_ot: cover property (ot_q ##1 !ot_q);
    c_wake: cover property (is_standby ##1 is_normal);

endmodule : ict_ctrl

`default_nettype wire

// [dv/ict_ctlr_model.sv]
// Protocol controller model: sends bytes as txd bits and drives the standby pin.
// Assumes the bench commands it and reads busy to know when a byte is done.
`default_nettype none
module ict_ctlr_model #(
    parameter int unsigned BIT_CYC = 12
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic [7:0] frame,
    input  wire logic       stuck_low,
    input  wire logic       stb_req,
    input  wire logic       stb_float,
    output var  logic       txd,
    output var  logic       stb,
    output var  logic       stb_driven,
    output var  logic       busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_q;
    logic [3:0] nb_q;
    logic [7:0] cnt_q;
    // =========================================================================
    // Bit timing, each bit far shorter than the dominant time-out
    always_ff @(posedge clock) begin
        if (srst) begin
            sh_q <= 8'hff;
            nb_q <= 4'h0;
            cnt_q <= 8'h00;
        end else if (start && nb_q == 4'h0) begin
            sh_q <= frame;
            nb_q <= 4'h8;
            cnt_q <= 8'h00;
        end else if (nb_q != 4'h0) begin
            if (cnt_q == 8'(BIT_CYC - 1)) begin
                cnt_q <= 8'h00;
                sh_q <= {sh_q[6:0], 1'b1};
                nb_q <= nb_q - 4'h1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    // Stuck low only when a fault case asks for it
    assign txd = stuck_low ? 1'b0 : (busy ? sh_q[7] : 1'b1);
    // Floating pin reads high through the pull-up
    assign stb = stb_float | stb_req;
    assign stb_driven = ~stb_float;
    assign busy = nb_q != 4'h0;
endmodule : ict_ctlr_model
`default_nettype wire

// [dv/ict_ctrl_tb_top.sv]
// Bench of the transceiver control block: APB master, pin stimulus and checks.
// Assumes the design package is compiled first and the controller model beside it.
`default_nettype none
module ict_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata, sd = 32'h837f88b6;
    logic pready, pslverr, rxd, irq, er, busy, txd, stb, stb_drv;
    logic start = 0, stuck = 0, stb_req = 1, stb_flt = 1, fchk = 0, rx_ext = 0, lp_dom = 0;
    logic below_stb = 0, above_max = 0, below_off = 0, ot = 0, ctrl_low = 0;
    logic [7:0] frame = 8'h00;
    logic [9:0] th = 10'h3ff;
    int n_errors = 0, num_checks = 0, cyc = 0;
    ict_pkg::ict_pins_s pins;
    ict_pkg::ict_bus_s bus;
    always #12.5 clock = ~clock;
    assign pins = '{txd: txd, stb: stb, stb_driven: stb_drv, ctrl_supply_low: ctrl_low,
        bus_supply_below_stb: below_stb, bus_supply_above_max: above_max,
        bus_supply_below_off: below_off, overtemp: ot,
        rx_dominant: bus.drive_dominant | rx_ext, lp_rx_dominant: lp_dom};
    ict_ctrl #(.DOM_TIMEOUT_CYC(120), .WAKE_FILTER_CYC(4)) u_ict_ctrl (.clock(clock),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pins(pins),
        .rxd(rxd), .bus(bus), .irq(irq));
    ict_ctlr_model u_ict_ctlr_model (.clock(clock), .srst(srst), .start(start),
        .frame(frame), .stuck_low(stuck), .stb_req(stb_req), .stb_float(stb_flt),
        .txd(txd), .stb(stb), .stb_driven(stb_drv), .busy(busy));
    // =========================================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic w(input int n);
        repeat (n) @(posedge clock);
    endtask : w
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic rs(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, ict_pkg::ADDR_STATUS, 32'h0);
        chk(rd & m, e);
    endtask : rs
    task automatic frm;
        sd = lfsr(sd);
        frame <= sd[7:0];
        start <= 1'b1;
        fchk <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        w(2);
        while (busy) @(posedge clock);
        w(10);
        fchk <= 1'b0;
    endtask : frm
    // =========================================================================
    // Timeout and bit-level monitor
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            end_sim();
        end
    end
    always @(posedge clock) begin
        th <= {th[8:0], txd};
        if (fchk && (th == 10'h3ff || th == 10'h000)) begin
            chk(bus.drive_dominant, !th[0]);
            chk(rxd, th[0]);
        end
    end
    // =========================================================================
    // Main sequence
    initial begin
        w(5);
        srst <= 1'b0;
        w(8);
        rs(32'h7f, 32'h22);
        chk({bus.drive_dominant, bus.bias_gnd, bus.lp_rx_en, bus.rx_normal_en}, 4'h6);
        apb(1'b1, ict_pkg::ADDR_IRQ_CLEAR, 32'h1f);
        sd = lfsr(sd);
        apb(1'b1, ict_pkg::ADDR_IRQ_ENABLE, sd);
        apb(1'b0, ict_pkg::ADDR_IRQ_ENABLE, 32'h0);
        chk(rd, sd & 32'h1f);
        apb(1'b1, ict_pkg::ADDR_IRQ_ENABLE, 32'h1f);
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        above_max <= 1'b1;
        stb_flt <= 1'b0;
        stb_req <= 1'b0;
        w(8);
        rs(32'h7f, 32'h04);
        chk({bus.bias_mid, bus.connected, bus.rx_normal_en, bus.lp_rx_en}, 4'he);
        for (int i = 0; i < 6; i++) begin
            sd = lfsr(sd);
            rx_ext <= sd[0];
            w(6);
            chk(rxd, !sd[0]);
        end
        rx_ext <= 1'b0;
        w(4);
        repeat (3) frm();
        stuck <= 1'b1;
        w(130);
        chk(bus.drive_dominant, 0);
        rs(32'h08, 32'h08);
        chk(irq, 1);
        apb(1'b0, ict_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1);
        stuck <= 1'b0;
        w(8);
        rs(32'h08, 0);
        apb(1'b1, ict_pkg::ADDR_IRQ_CLEAR, 32'h1f);
        chk(irq, 0);
        frm();
        stuck <= 1'b1;
        ot <= 1'b1;
        w(8);
        chk(bus.drive_dominant, 0);
        ot <= 1'b0;
        w(6);
        rs(32'h10, 32'h10);
        stuck <= 1'b0;
        w(8);
        rs(32'h10, 0);
        apb(1'b0, ict_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        frm();
        apb(1'b1, ict_pkg::ADDR_IRQ_CLEAR, 32'h1f);
        stb_req <= 1'b1;
        w(8);
        chk({bus.drive_dominant, bus.bias_gnd, bus.lp_rx_en, bus.rx_normal_en}, 4'h6);
        lp_dom <= 1'b1;
        w(3);
        lp_dom <= 1'b0;
        w(8);
        chk(rxd, 1);
        lp_dom <= 1'b1;
        w(12);
        chk(rxd, 0);
        stb_req <= 1'b0;
        lp_dom <= 1'b0;
        below_stb <= 1'b1;
        above_max <= 1'b0;
        w(12);
        rs(32'h27, 32'h22);
        lp_dom <= 1'b1;
        w(12);
        chk(rxd, 0);
        lp_dom <= 1'b0;
        below_stb <= 1'b0;
        w(12);
        chk(rxd, 1);
        rs(32'h27, 32'h22);
        apb(1'b0, ict_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        below_off <= 1'b1;
        w(8);
        rs(32'h07, 32'h01);
        chk({rxd, bus.connected, bus.drive_dominant}, 0);
        below_off <= 1'b0;
        w(8);
        rs(32'h07, 32'h02);
        chk({rxd, bus.drive_dominant}, 2'b10);
        above_max <= 1'b1;
        w(8);
        apb(1'b1, ict_pkg::ADDR_CTRL, 32'h1);
        rs(32'h07, 32'h02);
        apb(1'b1, ict_pkg::ADDR_CTRL, 32'h0);
        ctrl_low <= 1'b1;
        w(8);
        chk({bus.drive_dominant, rxd}, 2'b10);
        rs(32'h40, 32'h40);
        w(130);
        chk(bus.drive_dominant, 0);
        apb(1'b0, ict_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd & 32'h10, 32'h10);
        apb(1'b1, ict_pkg::ADDR_IRQ_ENABLE, 32'h0);
        chk(irq, 0);
        apb(1'b1, ict_pkg::ADDR_IRQ_ENABLE, 32'h10);
        chk(irq, 1);
        ctrl_low <= 1'b0;
        w(8);
        chk(rxd, 1);
        apb(1'b1, ict_pkg::ADDR_IRQ_CLEAR, 32'h1f);
        chk(irq, 0);
        end_sim();
    end
endmodule : ict_ctrl_tb_top
`default_nettype wire
